/* File: pkg/rcms_params.svh */
/*
  Offsets, reset values, field limits and timing figures of the radio control block.
  Assumes a 10 MHz aclk and a byte-addressed AXI4-Lite register window.
*/
`ifndef RCMS_PARAMS_SVH
`define RCMS_PARAMS_SVH

// register byte offsets
`define RCMS_OFF_CTRL 8'h00
`define RCMS_OFF_MASK 8'h04
`define RCMS_OFF_STAT 8'h08
`define RCMS_OFF_RDS0 8'h0c
`define RCMS_OFF_RDS1 8'h10
`define RCMS_AW 8

// reset values
`define RCMS_CTRL_RST 32'h0000e844
`define RCMS_MASK_RST 5'h00
`define RCMS_RDS_RST 32'h00000000

// bus answers
`define RCMS_RESP_OK 2'h0
`define RCMS_RESP_ERR 2'h2

// timing
`define RCMS_CLK_NS 100
`define RCMS_MS_NS 1000000
`define RCMS_START_NS 900000
`define RCMS_CNT_W 14

// level comparison
`define RCMS_LVL_MIN 4'h3
`define RCMS_HYST_LARGE 4'h2
`define RCMS_HYST_SMALL 4'h1

// pause detector: threshold step in dB, durations in ms
`define RCMS_PAUSE_STEP 6'h04
`define RCMS_PAUSE_MS0 8'h05
`define RCMS_PAUSE_MS1 8'h0a
`define RCMS_PAUSE_MS2 8'h14
`define RCMS_PAUSE_MS3 8'h28

`endif

/* File: pkg/rcms_pkg.sv */
/*
  Types of the radio control block: control word, status word, pins, outputs, state.
  Assumes rcms_params.svh is on the include path.
*/
`include "rcms_params.svh"

package rcms_pkg;

  typedef enum logic [1:0] {
    RCMS_PWR_STBY = 2'b00,
    RCMS_PWR_FM = 2'b01,
    RCMS_PWR_RSV = 2'b10,
    RCMS_PWR_FULL = 2'b11
  } rcms_pwr_e;

  typedef enum logic [1:0] {
    RCMS_ST_OFF = 2'b00,
    RCMS_ST_START = 2'b01,
    RCMS_ST_RUN = 2'b10
  } rcms_rds_e;

  typedef struct packed {
    logic [9:0] rsv;
    logic [1:0] pause_duration;
    logic [1:0] pause_threshold;
    logic [3:0] level_threshold;
    logic hysteresis_size_select;
    logic blend_switched;
    logic stereo_noise_cancel;
    logic rds_direct_output;
    logic diagnostic_select;
    logic port_source_select;
    logic port_data_bit;
    logic audio_silence;
    logic right_output_tristate;
    logic left_output_tristate;
    logic output_tristate_all;
    logic soft_attenuation_enable;
    rcms_pwr_e power_up_control;
  } rcms_ctrl_s;

  // flags order: audio_pause, rds_sync_lost, rds_data_available, tuning_ready, low_level
  typedef struct packed {
    logic [20:0] rsv;
    logic search_stop_ok;
    logic startup_done;
    logic [4:0] flags;
    logic [3:0] level;
  } rcms_stat_s;

  typedef struct packed {
    logic [3:0] level;
    logic [5:0] audio_level;
    logic tuned;
    logic tuning_ready_flag;
    logic diag_signal;
    logic rds_bit_value;
    logic rds_bit_clock;
    logic rds_update_busy;
  } rcms_pins_s;

  typedef struct packed {
    logic left_audio_out;
    logic left_audio_oe;
    logic right_audio_out;
    logic right_audio_oe;
    logic rds_route;
    logic audio_block;
    logic soft_en;
    logic force_mono;
    logic snc_en;
    logic blend_sw;
    logic port_out;
    logic fm_power;
    logic rds_power;
    logic search_stop_ok;
    logic interrupt_out_n;
  } rcms_out_s;

  typedef struct packed {
    rcms_pins_s s1;
    rcms_pins_s s2;
    rcms_ctrl_s ctrl;
    logic [4:0] mask;
    logic [2:0] rflags;
    logic [3:0] level;
    logic low_flag;
    logic stop_ok;
    logic [31:0] rds0;
    logic [31:0] rds1;
    rcms_rds_e rds_st;
    logic [`RCMS_CNT_W-1:0] start_cnt;
    logic [`RCMS_CNT_W-1:0] ms_cnt;
    logic [7:0] pause_ms;
    logic pause_armed;
    logic awv;
    logic wv;
    logic [`RCMS_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    rcms_out_s out;
  } rcms_state_s;

endpackage

/* File: hdl/rcms_level_cmp.sv */
/*
  Field-strength level comparator with tuned-state hysteresis.
  Assumes level, threshold and tuned are already synchronous to the caller's clock.
*/
`include "rcms_params.svh"
module rcms_level_cmp
  import rcms_pkg::*;
#(
  parameter int W = 4
)(
  // level and settings
  input wire logic [W-1:0] level,
  input wire logic [W-1:0] threshold,
  input wire logic hyst_large,
  input wire logic tuned,
  // results
  output logic low,
  output logic stop_ok
);

  logic [W-1:0] step;
  logic [W-1:0] limit;

  if (W < 3)
  begin : g_chk
    $error("rcms_level_cmp: W must be at least 3");
  end

  always_comb
  begin
    step = hyst_large ? W'(`RCMS_HYST_LARGE) : W'(`RCMS_HYST_SMALL);
    if (!tuned)
      limit = threshold;
    else if (threshold <= W'(`RCMS_LVL_MIN))
      limit = '0;
    else if (threshold > step)
      limit = threshold - step;
    else
      limit = '0;
    low = level < limit;
    stop_ok = level >= threshold;
  end

endmodule

/* File: hdl/rcms_top.sv */
/*
  Digital control of the receiver: level flag, mutes, blend, port, standby, start-up,
  rds data flags, pause detector and interrupt pin, behind an AXI4-Lite slave.
  Assumes pins_in comes from other clock domains; rds_block_* come from logic on aclk.
*/
`include "rcms_params.svh"

////////////////////////////////////////////////////////////////////////////////
module rcms_top
  import rcms_pkg::*;
#(
  parameter int STARTUP_CYCLES = `RCMS_START_NS / `RCMS_CLK_NS,
  parameter int MS_CYCLES = `RCMS_MS_NS / `RCMS_CLK_NS
)(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [`RCMS_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [`RCMS_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // asynchronous inputs from analog and demodulator sections
  input wire rcms_pins_s pins_in,
  // rds decoder on aclk
  input wire logic rds_block_valid,
  input wire logic [31:0] rds_block_data,
  input wire logic rds_sync_lost,
  // controls and pins
  output rcms_out_s ctl_out
);

  localparam logic [`RCMS_CNT_W-1:0] START_LAST = `RCMS_CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [`RCMS_CNT_W-1:0] MS_LAST = `RCMS_CNT_W'(MS_CYCLES - 1);

  if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= 2 ** `RCMS_CNT_W ||
      MS_CYCLES < 1 || MS_CYCLES >= 2 ** `RCMS_CNT_W)
  begin : g_chk
    $error("rcms_top: counts must lie in 1 .. 2**RCMS_CNT_W-1");
  end

  rcms_state_s r_r;
  rcms_state_s r_nxt;
  rcms_stat_s stat;
  logic cmp_low;
  logic cmp_stop;
  logic fm_on;
  logic rds_on;
  logic ms_tick;
  logic [31:0] wmerged;
  logic [4:0] live_flags;
  logic [5:0] pause_limit;
  logic [7:0] pause_target;

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        res[8*i +: 8] = nw[8*i +: 8];
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  rcms_level_cmp #(
    .W(4)
  ) u_cmp (
    .level(r_r.s2.level),
    .threshold(r_r.ctrl.level_threshold),
    .hyst_large(r_r.ctrl.hysteresis_size_select),
    .tuned(r_r.s2.tuned),
    .low(cmp_low),
    .stop_ok(cmp_stop)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    r_nxt = r_r;
    wmerged = '0;
    stat = '0;
    // two-stage synchroniser for every pin input
    r_nxt.s1 = pins_in;
    r_nxt.s2 = r_r.s1;

    fm_on = (r_r.ctrl.power_up_control == RCMS_PWR_FM) || (r_r.ctrl.power_up_control == RCMS_PWR_FULL);
    rds_on = r_r.ctrl.power_up_control == RCMS_PWR_FULL;
    ms_tick = r_r.ms_cnt == MS_LAST;
    live_flags = {r_r.rflags, r_r.s2.tuning_ready_flag, r_r.low_flag};

    r_nxt.level = r_r.s2.level;
    r_nxt.low_flag = cmp_low;
    r_nxt.stop_ok = cmp_stop;

    // write path: address and data taken in either order, answered once both are held
    if (s_axi_awvalid && r_r.awready)
    begin
      r_nxt.awv = 1'b1;
      r_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_r.wready)
    begin
      r_nxt.wv = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    if (r_r.bvalid && s_axi_bready)
      r_nxt.bvalid = 1'b0;
    if (r_r.awv && r_r.wv && !r_r.bvalid)
    begin
      r_nxt.awv = 1'b0;
      r_nxt.wv = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = `RCMS_RESP_OK;
      case (r_r.awaddr)
        `RCMS_OFF_CTRL:
        begin
          wmerged = strb_merge(r_r.ctrl, r_r.wdata, r_r.wstrb);
          r_nxt.ctrl = rcms_ctrl_s'(wmerged);
          r_nxt.ctrl.rsv = '0;
          if (r_nxt.ctrl.level_threshold < `RCMS_LVL_MIN)
            r_nxt.ctrl.level_threshold = `RCMS_LVL_MIN;
        end
        `RCMS_OFF_MASK:
        begin
          wmerged = strb_merge({27'h0, r_r.mask}, r_r.wdata, r_r.wstrb);
          r_nxt.mask = wmerged[4:0];
        end
        `RCMS_OFF_STAT, `RCMS_OFF_RDS0, `RCMS_OFF_RDS1:
          r_nxt.bresp = `RCMS_RESP_OK;
        default:
          r_nxt.bresp = `RCMS_RESP_ERR;
      endcase
    end
    r_nxt.awready = !r_nxt.awv && !r_nxt.bvalid;
    r_nxt.wready = !r_nxt.wv && !r_nxt.bvalid;

    // read path; a status read clears the sticky rds and pause flags
    stat.level = r_r.level;
    stat.flags = live_flags;
    stat.startup_done = r_r.rds_st == RCMS_ST_RUN;
    stat.search_stop_ok = r_r.stop_ok;
    if (r_r.rvalid && s_axi_rready)
      r_nxt.rvalid = 1'b0;
    if (s_axi_arvalid && r_r.arready)
    begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp = `RCMS_RESP_OK;
      case (s_axi_araddr)
        `RCMS_OFF_CTRL:
          r_nxt.rdata = r_r.ctrl;
        `RCMS_OFF_MASK:
          r_nxt.rdata = {27'h0, r_r.mask};
        `RCMS_OFF_STAT:
        begin
          r_nxt.rdata = stat;
          r_nxt.rflags = 3'h0;
        end
        `RCMS_OFF_RDS0:
          r_nxt.rdata = r_r.rds0;
        `RCMS_OFF_RDS1:
          r_nxt.rdata = r_r.rds1;
        default:
        begin
          r_nxt.rdata = '0;
          r_nxt.rresp = `RCMS_RESP_ERR;
        end
      endcase
    end
    r_nxt.arready = !r_nxt.rvalid;

    // rds section start-up after power-up
    case (r_r.rds_st)
      RCMS_ST_OFF:
      begin
        r_nxt.start_cnt = '0;
        if (rds_on)
          r_nxt.rds_st = RCMS_ST_START;
      end
      RCMS_ST_START:
      begin
        if (!rds_on)
          r_nxt.rds_st = RCMS_ST_OFF;
        else if (r_r.start_cnt == START_LAST)
        begin
          r_nxt.rds_st = RCMS_ST_RUN;
          r_nxt.rds0 = `RCMS_RDS_RST;
          r_nxt.rds1 = `RCMS_RDS_RST;
          r_nxt.rflags = 3'h0;
        end
        else
          r_nxt.start_cnt = r_r.start_cnt + 1'b1;
      end
      RCMS_ST_RUN:
        if (!rds_on)
          r_nxt.rds_st = RCMS_ST_OFF;
      default:
        r_nxt.rds_st = RCMS_ST_OFF;
    endcase

    // new rds block; delivery needs audio silence set
    if (r_r.rds_st == RCMS_ST_RUN && rds_block_valid && r_r.ctrl.audio_silence)
    begin
      r_nxt.rds0 = r_r.rds1;
      r_nxt.rds1 = rds_block_data;
      r_nxt.rflags[0] = 1'b1;
    end
    if (r_r.rds_st == RCMS_ST_RUN && rds_sync_lost)
      r_nxt.rflags[1] = 1'b1;

    // pause detector on a millisecond tick
    r_nxt.ms_cnt = ms_tick ? '0 : r_r.ms_cnt + 1'b1;
    pause_limit = {2'h0, r_r.ctrl.pause_threshold, 2'h0} + `RCMS_PAUSE_STEP;
    case (r_r.ctrl.pause_duration)
      2'h0: pause_target = `RCMS_PAUSE_MS0;
      2'h1: pause_target = `RCMS_PAUSE_MS1;
      2'h2: pause_target = `RCMS_PAUSE_MS2;
      default: pause_target = `RCMS_PAUSE_MS3;
    endcase
    if (!fm_on || r_r.s2.audio_level >= pause_limit)
    begin
      r_nxt.pause_ms = '0;
      r_nxt.pause_armed = 1'b1;
    end
    else
    begin
      if (ms_tick && r_r.pause_ms < pause_target)
        r_nxt.pause_ms = r_r.pause_ms + 8'h01;
      if (r_r.pause_armed && r_r.pause_ms >= pause_target)
      begin
        r_nxt.pause_armed = 1'b0;
        if (r_r.rds_st == RCMS_ST_RUN)
          r_nxt.rflags[2] = 1'b1;
      end
    end

    // outputs
    r_nxt.out.left_audio_oe = fm_on && !r_r.ctrl.output_tristate_all && !r_r.ctrl.left_output_tristate;
    r_nxt.out.right_audio_oe = fm_on && !r_r.ctrl.output_tristate_all && !r_r.ctrl.right_output_tristate;
    r_nxt.out.rds_route = r_r.ctrl.rds_direct_output;
    r_nxt.out.left_audio_out = r_r.ctrl.rds_direct_output && r_r.s2.rds_bit_value;
    r_nxt.out.right_audio_out = r_r.ctrl.rds_direct_output && r_r.s2.rds_bit_clock;
    r_nxt.out.audio_block = r_r.ctrl.audio_silence || r_r.s2.rds_update_busy;
    r_nxt.out.soft_en = r_r.ctrl.soft_attenuation_enable;
    r_nxt.out.force_mono = r_r.ctrl.left_output_tristate || r_r.ctrl.right_output_tristate;
    r_nxt.out.snc_en = r_r.ctrl.stereo_noise_cancel;
    r_nxt.out.blend_sw = r_r.ctrl.blend_switched;
    if (r_r.ctrl.diagnostic_select)
      r_nxt.out.port_out = r_r.s2.diag_signal;
    else if (r_r.ctrl.port_source_select)
      r_nxt.out.port_out = r_r.s2.tuning_ready_flag;
    else
      r_nxt.out.port_out = r_r.ctrl.port_data_bit;
    r_nxt.out.fm_power = fm_on;
    r_nxt.out.rds_power = rds_on;
    r_nxt.out.search_stop_ok = r_r.stop_ok;
    r_nxt.out.interrupt_out_n = !(|(live_flags & r_r.mask));

    // synchronous reset; rds words and their flags are kept
    if (!aresetn)
    begin
      r_nxt = '0;
      r_nxt.ctrl = rcms_ctrl_s'(`RCMS_CTRL_RST);
      r_nxt.mask = `RCMS_MASK_RST;
      r_nxt.awready = 1'b1;
      r_nxt.wready = 1'b1;
      r_nxt.arready = 1'b1;
      r_nxt.out.interrupt_out_n = 1'b1;
      r_nxt.rds0 = r_r.rds0;
      r_nxt.rds1 = r_r.rds1;
      r_nxt.rflags = r_r.rflags;
    end
  end

  always_ff @(posedge aclk)
  begin
    r_r <= r_nxt;
  end

  assign s_axi_awready = r_r.awready;
  assign s_axi_wready = r_r.wready;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp = r_r.bresp;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;
  assign ctl_out = r_r.out;

  ////////////////////////////////////////////////////////////////////////////////
  property p_all_tristate;
    @(posedge aclk) disable iff (!aresetn)
    r_r.ctrl.output_tristate_all |=> !ctl_out.left_audio_oe && !ctl_out.right_audio_oe;
  endproperty
  a_all_tristate: assert property (p_all_tristate) else $error("audio driven under global tristate");

  property p_side_mono;
    @(posedge aclk) disable iff (!aresetn)
    r_r.ctrl.left_output_tristate && !r_r.ctrl.right_output_tristate && !r_r.ctrl.output_tristate_all && fm_on
    |=> ctl_out.force_mono && !ctl_out.left_audio_oe && ctl_out.right_audio_oe;
  endproperty
  a_side_mono: assert property (p_side_mono) else $error("left tristate not independent or not mono");

  property p_standby;
    @(posedge aclk) disable iff (!aresetn)
    r_r.ctrl.power_up_control == RCMS_PWR_STBY |=> !ctl_out.left_audio_oe && !ctl_out.right_audio_oe;
  endproperty
  a_standby: assert property (p_standby) else $error("audio driven in standby");

  property p_silence;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && (r_r.ctrl.audio_silence || r_r.s2.rds_update_busy) |=> ctl_out.audio_block;
  endproperty
  a_silence: assert property (p_silence) else $error("audio not blocked");

  property p_rds_gate;
    @(posedge aclk) disable iff (!aresetn)
    $rose(r_r.rflags[0]) |-> $past(r_r.ctrl.audio_silence) && $past(rds_block_valid);
  endproperty
  a_rds_gate: assert property (p_rds_gate) else $error("rds data delivered with silence clear");

  property p_port;
    @(posedge aclk) disable iff (!aresetn)
    !r_r.ctrl.diagnostic_select ##1 !r_r.ctrl.diagnostic_select
    |-> ctl_out.port_out == ($past(r_r.ctrl.port_source_select) ? $past(r_r.s2.tuning_ready_flag)
                                                                 : $past(r_r.ctrl.port_data_bit));
  endproperty
  a_port: assert property (p_port) else $error("port source wrong");

  property p_diag;
    @(posedge aclk) disable iff (!aresetn)
    r_r.ctrl.diagnostic_select |=> ctl_out.port_out == $past(r_r.s2.diag_signal);
  endproperty
  a_diag: assert property (p_diag) else $error("port not showing test signal");

  property p_reset;
    @(posedge aclk)
    !aresetn |=> r_r.ctrl.power_up_control == RCMS_PWR_STBY && r_r.rds_st == RCMS_ST_OFF && ctl_out.interrupt_out_n;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not enter standby");

  property p_startup;
    @(posedge aclk) disable iff (!aresetn)
    $rose(r_r.rds_st == RCMS_ST_RUN) |-> $past(r_r.start_cnt) == START_LAST && r_r.rflags == 3'h0;
  endproperty
  a_startup: assert property (p_startup) else $error("rds start-up time or defaults wrong");

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    (|(live_flags & r_r.mask)) |=> !ctl_out.interrupt_out_n;
  endproperty
  a_irq: assert property (p_irq) else $error("masked-in flag did not pull interrupt low");

  property p_rhold;
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped before rready");

endmodule

/* File: tb/rcms_far_model.sv */
/*
  Far-side model: analog pins and rds decoder feeding the radio control block.
  Assumes the bench calls its tasks just after a rising edge of aclk.
*/
module rcms_far_model
  import rcms_pkg::*;
(
  // clock
  input wire logic aclk,
  // toward the block
  output rcms_pins_s pins,
  output logic blk_v,
  output logic [31:0] blk_d,
  output logic sync_lost
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    pins = '0;
    pins.audio_level = 6'h3f;
    blk_v = 1'b0;
    blk_d = 32'h0;
    sync_lost = 1'b0;
  end

  task automatic set_pins(input rcms_pins_s p);
    pins <= p;
  endtask

  // block strobe, held up for a second block back to back when two is set; data scrambled once released
  task automatic send_blocks(input logic [31:0] v0, input logic [31:0] v1, input bit two);
    blk_v <= 1'b1;
    blk_d <= v0;
    @(posedge aclk);
    if (two)
    begin
      blk_d <= v1;
      @(posedge aclk);
    end
    blk_v <= 1'b0;
    blk_d <= ~v1;
  endtask

  // one-cycle loss of rds block sync
  task automatic lose_sync;
    sync_lost <= 1'b1;
    @(posedge aclk);
    sync_lost <= 1'b0;
  endtask
endmodule

/* File: tb/radio_control_mute_standby_tb.sv */
/*
  Self-checking bench of the radio control block over AXI4-Lite.
  Assumes rcms_top with shortened start-up and millisecond counts.
*/
module radio_control_mute_standby_tb;
  import rcms_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 20;
  localparam int MC = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, blk_v, sync_lost;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, c, e, b1, b2, blk_d;
  rcms_pins_s pins, p;
  rcms_out_s co;
  int n_errors = 0;
  int n_tests = 0;

  always #50 aclk = ~aclk;

  rcms_top #(.STARTUP_CYCLES(SC), .MS_CYCLES(MC)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins_in(pins), .rds_block_valid(blk_v), .rds_block_data(blk_d),
    .rds_sync_lost(sync_lost), .ctl_out(co)
  );

  rcms_far_model i_far (.aclk(aclk), .pins(pins), .blk_v(blk_v), .blk_d(blk_d), .sync_lost(sync_lost));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %0t: got %h expected %h", $time, s, e);
    end
  endtask

  task automatic bound(input int k);
    if (k == 40)
    begin
      n_errors++;
      report_and_stop();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        break;
    end
    r = bresp;
    bound(k);
  endtask

  task automatic rd(input logic [7:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++)
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        break;
    end
    d = rdata;
    r = rresp;
    bound(k);
  endtask

  // oe pair, mono, soft, block, route, snc, blend, port, fm, rds, rds data and clock pins, search stop
  function automatic logic [31:0] exp_out(input logic [31:0] v, input rcms_pins_s q);
    logic fm;
    fm = v[0];
    return {18'h0, fm & ~v[3] & ~v[4], fm & ~v[3] & ~v[5], v[4] | v[5], v[2], v[6], v[10], v[11], v[12],
      v[9] ? q.diag_signal : (v[8] ? q.tuning_ready_flag : v[7]), fm, v[1:0] == 2'b11,
      v[10] & q.rds_bit_value, v[10] & q.rds_bit_clock, q.level >= v[17:14]};
  endfunction

  // search stop, tuning ready, low level and level against the stored threshold
  function automatic logic [6:0] exp_stat(input logic [31:0] v, input rcms_pins_s q);
    logic [3:0] lim;
    if (!q.tuned)
      lim = v[17:14];
    else if (v[17:14] == 4'h3)
      lim = 4'h0;
    else
      lim = v[17:14] - (v[13] ? 4'h2 : 4'h1);
    return {q.level >= v[17:14], q.tuning_ready_flag, q.level < lim, q.level};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    c = $urandom(37552);
    tick(2);
    aresetn <= 1'b1;
    rd(8'h00);
    chk(d, 32'h0000e844);
    rd(8'h04);
    chk(d, 32'h0);
    chk(32'({co.left_audio_oe, co.right_audio_oe, co.fm_power, co.interrupt_out_n}), 32'h1);
    rd(8'h14);
    chk(32'(r), 32'h2);
    $display("reset test done");
    for (int i = 0; i < 12; i++)
    begin
      p = rcms_pins_s'(16'($urandom));
      p.audio_level = 6'h3f;
      p.rds_update_busy = 1'b0;
      i_far.set_pins(p);
      c = $urandom & 32'h3ffff;
      e = c;
      if (c[17:14] < 4'h3)
        e[17:14] = 4'h3;
      wr(8'h00, c);
      tick(4);
      chk({18'h0, co.left_audio_oe, co.right_audio_oe, co.force_mono, co.soft_en, co.audio_block, co.rds_route,
        co.snc_en, co.blend_sw, co.port_out, co.fm_power, co.rds_power, co.left_audio_out, co.right_audio_out,
        co.search_stop_ok}, exp_out(e, p));
      rd(8'h00);
      chk(d, e);
      chk(32'(d[17:14]), 32'(e[17:14]));
      rd(8'h08);
      chk(32'({d[10], d[5:0]}), 32'(exp_stat(e, p)));
    end
    $display("control test done");
    wr(8'h00, 32'he840);
    wr(8'h04, 32'h14);
    wr(8'h00, 32'he847);
    rd(8'h08);
    chk(32'(d[9]), 32'h0);
    tick(SC + 4);
    rd(8'h08);
    chk(32'(d[9:6]), 32'h8);
    rd(8'h0c);
    chk(d, 32'h0);
    b1 = $urandom;
    b2 = $urandom;
    i_far.send_blocks(b1, b2, 1'b1);
    i_far.lose_sync();
    tick(2);
    chk(32'(co.interrupt_out_n), 32'h0);
    rd(8'h10);
    chk(d, b2);
    rd(8'h0c);
    chk(d, b1);
    rd(8'h08);
    chk(32'(d[6]), 32'h1);
    chk(32'(d[7]), 32'h1);
    rd(8'h08);
    chk(32'(d[6]), 32'h0);
    tick(3);
    chk(32'(co.interrupt_out_n), 32'h1);
    wr(8'h00, 32'he807);
    i_far.send_blocks(~b2, ~b2, 1'b0);
    p.rds_update_busy = 1'b1;
    i_far.set_pins(p);
    tick(5);
    chk(32'(co.audio_block), 32'h1);
    rd(8'h10);
    chk(d, b2);
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    rd(8'h10);
    chk(d, b2);
    wr(8'h04, 32'h14);
    $display("rds test done");
    p.rds_update_busy = 1'b0;
    p.audio_level = 6'h00;
    i_far.set_pins(p);
    wr(8'h00, 32'he847);
    tick(7 * MC);
    chk(32'(co.interrupt_out_n), 32'h0);
    rd(8'h08);
    chk(32'(d[8]), 32'h1);
    tick(7 * MC);
    rd(8'h08);
    chk(32'(d[8]), 32'h0);
    $display("pause test done");
    report_and_stop();
  end
endmodule
